/* dpl_host.sv */
/* dpl_host: host controller model issuing object requests.
   assumes callers enter acc between falling edges of clk. */
module dpl_host
  import dpl_pkg::*;
(
  input wire logic clk, // clock
  output dpl_pkg::dpl_req_s req, // request
  output logic req_valid // strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    req = '0;
    req_valid = 1'b0;
  end
  // one-cycle strobe; fields scrambled once released
  task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d);
    @(negedge clk);
    req = '{index: i, write: w, wdata: d};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    req = ~req;
  endtask
endmodule

/* dpl_latch.sv */
/*
  dpl_latch: two-channel probe position latch with its object registers.
  Assumes motor_position and the request port come from logic on clk;
  probe pins, encoder index and encoder external input are asynchronous
  and are synchronised here. Reset is synchronous and held long enough
  to flush the synchronisers.
*/
// Contract
// R1: capture position on probe or index trigger
// R2: two probes run together, low byte probe one
// R3: bit1 selects single or continuous latching
// R4: bit2 selects probe pin or index source
// R5: bit4 enables rising edge latch
// R6: bit5 enables falling edge latch
// R7: bit8 enables probe two, bit9 mode
// R8: bit10 selects probe two source
// R9: bit12 enables probe two rising latch
// R10: bit13 enables probe two falling latch
// R11: status word reports probe one state
// R12: probe one captures stored in position registers
// R13: index or encoder external input triggers latch
// R14: status edge done flags per probe
// R15: continuous mode two-bit wrap counter
// R16: probe two edges go to own registers
// R17: synchronise, detect edge, capture same cycle
// R18: disable clears flags, re-enable re-arms
// R19: reserved bits ignored, read zero
module dpl_latch
  import dpl_pkg::*;
(
  input wire logic clk, // 40 MHz clock
  input wire logic reset, // synchronous, active high
  input wire dpl_pkg::dpl_req_s req, // object access request
  input wire logic req_valid, // request strobe, one cycle
  input wire logic [31:0] motor_position, // feedback position, same clock
  input wire logic probe_input_one, // probe one pin
  input wire logic probe_input_two, // probe two pin
  input wire logic encoder_index, // encoder index (c) pulse
  input wire logic encoder_external_input, // encoder external trigger input
  output logic [31:0] rdata, // read data
  output logic rvalid, // read data valid, one cycle
  output logic probe_one_hit, // probe one captured, one cycle
  output logic probe_two_hit // probe two captured, one cycle
);
  import dpl_pkg::*;

  logic [15:0] control_r;
  logic [31:0] pos_r [4];
  dpl_chan_st_s st_r [2];
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  logic armed_r [2];
  logic [31:0] rdata_r;
  logic rvalid_r;
  logic [1:0] hit_r;

  function automatic dpl_chan_cfg_s cfg_of(input logic [7:0] b);
    dpl_chan_cfg_s c;
    c.enable = b[BIT_ENABLE];
    c.continuous = b[BIT_CONTINUOUS];
    c.source_index = b[BIT_SOURCE_INDEX];
    c.rise_en = b[BIT_RISE_EN];
    c.fall_en = b[BIT_FALL_EN];
    return c;
  endfunction

  function automatic logic [15:0] st_word(input dpl_chan_st_s s);
    logic [15:0] w;
    w = 16'h0000;
    w[BIT_ENABLE] = s.enable;
    w[BIT_ST_RISE_DONE] = s.rise_done;
    w[BIT_ST_FALL_DONE] = s.fall_done;
    w[BIT_ST_COUNT +: 2] = s.count;
    return w;
  endfunction

  // sync order: probe one, probe two, index, encoder external input
  wire [3:0] pins = {encoder_external_input, encoder_index, probe_input_two, probe_input_one};
  // rise/fall seen on s2 vs s3; s1 is only read by s2
  wire [3:0] rise = s2_r & ~s3_r; // R17
  wire [3:0] fall = ~s2_r & s3_r; // R17
  // index source: index pulse or encoder external input
  wire idx_rise = rise[2] | rise[3]; // R13
  wire idx_fall = fall[2] | fall[3]; // R13

  wire dpl_chan_cfg_s cfg [2];
  assign cfg[0] = cfg_of(control_r[7:0]); // R2
  assign cfg[1] = cfg_of(control_r[15:8]); // R7

  wire [15:0] status_word = st_word(st_r[0]) | (st_word(st_r[1]) << CH_TWO_BASE); // R11 R19

  // request decode: only the control object takes writes
  wire wr = req_valid & req.write;
  wire rd_req = req_valid & ~req.write;
  wire wr_ctl = wr & (req.index == IDX_CONTROL);
  wire [15:0] ctl_wdata = req.wdata[15:0] & CONTROL_MASK; // R19
  wire [15:0] control_nxt = wr_ctl ? ctl_wdata : control_r;

  // one channel's status after this cycle
  function automatic dpl_chan_st_s st_next(
    input dpl_chan_st_s s,
    input dpl_chan_cfg_s c,
    input logic tr,
    input logic tf
  );
    dpl_chan_st_s n;
    n = s;
    if (!c.enable)
    begin
      n = '0; // R18
    end
    else
    begin
      n.enable = 1'h1;
      if (tr)
        n.rise_done = 1'h1; // R14
      if (tf)
        n.fall_done = 1'h1; // R14
      if ((tr | tf) && c.continuous)
        n.count = s.count + 2'h1; // R15
    end
    return n;
  endfunction

  // armed while disabled or continuous; a single-mode capture disarms until re-enabled
  function automatic logic arm_next(
    input logic armed,
    input dpl_chan_cfg_s c,
    input logic took
  );
    logic a;
    a = armed;
    if (!c.enable || c.continuous)
      a = 1'h1; // R18
    else if (took)
      a = 1'h0; // R3
    return a;
  endfunction

  // trigger per channel: own pin, or index/external input when source bit set
  wire [1:0] sel_rise;
  wire [1:0] sel_fall;
  assign sel_rise[0] = cfg[0].source_index ? idx_rise : rise[0]; // R4
  assign sel_fall[0] = cfg[0].source_index ? idx_fall : fall[0]; // R4
  assign sel_rise[1] = cfg[1].source_index ? idx_rise : rise[1]; // R8
  assign sel_fall[1] = cfg[1].source_index ? idx_fall : fall[1]; // R8

  // a channel may latch only while enabled and still armed
  wire [1:0] live;
  assign live[0] = cfg[0].enable & armed_r[0]; // R2
  assign live[1] = cfg[1].enable & armed_r[1]; // R7

  wire [1:0] take_rise;
  wire [1:0] take_fall;
  wire [1:0] take_any;
  assign take_rise[0] = live[0] & cfg[0].rise_en & sel_rise[0]; // R5
  assign take_fall[0] = live[0] & cfg[0].fall_en & sel_fall[0]; // R6
  assign take_rise[1] = live[1] & cfg[1].rise_en & sel_rise[1]; // R9
  assign take_fall[1] = live[1] & cfg[1].fall_en & sel_fall[1]; // R10
  assign take_any = take_rise | take_fall; // R1

  wire dpl_chan_st_s st_nxt [2];
  wire armed_nxt [2];
  assign st_nxt[0] = st_next(st_r[0], cfg[0], take_rise[0], take_fall[0]); // R14 R15
  assign st_nxt[1] = st_next(st_r[1], cfg[1], take_rise[1], take_fall[1]); // R14 R15
  assign armed_nxt[0] = arm_next(armed_r[0], cfg[0], take_any[0]); // R3
  assign armed_nxt[1] = arm_next(armed_r[1], cfg[1], take_any[1]); // R7

  // rise fills the even slot, fall the odd slot, with the position of the take cycle
  wire [31:0] pos_nxt [4];
  assign pos_nxt[0] = take_rise[0] ? motor_position : pos_r[0]; // R1 R12 R17
  assign pos_nxt[1] = take_fall[0] ? motor_position : pos_r[1]; // R1 R12 R17
  assign pos_nxt[2] = take_rise[1] ? motor_position : pos_r[2]; // R16
  assign pos_nxt[3] = take_fall[1] ? motor_position : pos_r[3]; // R16

  logic [31:0] rd_mux;
  always_comb
  begin
    unique case (req.index)
      IDX_CONTROL: rd_mux = {16'h0000, control_r};
      IDX_STATUS: rd_mux = {16'h0000, status_word};
      IDX_ONE_RISE: rd_mux = pos_r[0];
      IDX_ONE_FALL: rd_mux = pos_r[1];
      IDX_TWO_RISE: rd_mux = pos_r[2];
      IDX_TWO_FALL: rd_mux = pos_r[3];
      default: rd_mux = 32'h00000000;
    endcase
  end

  wire [31:0] rdata_nxt = rd_req ? rd_mux : rdata_r; // R11
  wire rvalid_nxt = rd_req;
  wire [1:0] hit_nxt = take_any;

  // two-flop synchroniser, third stage only for edge detection
  always_ff @(posedge clk)
  begin
    s1_r <= pins;
    s2_r <= s1_r; // R17
    s3_r <= s2_r;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      control_r <= CONTROL_RESET;
    else
      control_r <= control_nxt;
  end

  // probe one positions
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pos_r[0] <= POSITION_RESET;
      pos_r[1] <= POSITION_RESET;
    end
    else
    begin
      pos_r[0] <= pos_nxt[0];
      pos_r[1] <= pos_nxt[1];
    end
  end

  // probe two positions
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pos_r[2] <= POSITION_RESET;
      pos_r[3] <= POSITION_RESET;
    end
    else
    begin
      pos_r[2] <= pos_nxt[2];
      pos_r[3] <= pos_nxt[3];
    end
  end

  // probe one status and arming
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_r[0] <= '0;
      armed_r[0] <= 1'h1;
    end
    else
    begin
      st_r[0] <= st_nxt[0];
      armed_r[0] <= armed_nxt[0];
    end
  end

  // probe two status and arming
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_r[1] <= '0;
      armed_r[1] <= 1'h1;
    end
    else
    begin
      st_r[1] <= st_nxt[1];
      armed_r[1] <= armed_nxt[1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rdata_r <= READ_RESET;
    else
      rdata_r <= rdata_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rvalid_r <= 1'h0;
    else
      rvalid_r <= rvalid_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      hit_r <= 2'h0;
    else
      hit_r <= hit_nxt;
  end

  assign rdata = rdata_r;
  assign rvalid = rvalid_r;
  assign probe_one_hit = hit_r[0];
  assign probe_two_hit = hit_r[1];
endmodule

/* dpl_latch_checker.sv */
/* dpl_chk: port assertions for dpl_latch.
   assumes the bind below attaches it to every dpl_latch. */
module dpl_chk
  import dpl_pkg::*;
(
  input wire logic clk, // clock
  input wire logic reset, // reset
  input wire dpl_pkg::dpl_req_s req, // request
  input wire logic req_valid, // strobe
  input wire logic [31:0] motor_position, // position
  input wire logic probe_input_one, // pin
  input wire logic probe_input_two, // pin
  input wire logic encoder_index, // pin
  input wire logic encoder_external_input, // pin
  input wire logic [31:0] rdata, // read data
  input wire logic rvalid, // read valid
  input wire logic probe_one_hit, // hit
  input wire logic probe_two_hit // hit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pin_r;
  logic [2:0] quiet_r;
  wire [3:0] pins = {probe_input_one, probe_input_two, encoder_index, encoder_external_input};
  // cycles since any trigger pin last moved, saturating
  always_ff @(posedge clk)
  begin
    pin_r <= pins;
    quiet_r <= reset ? 3'h7 : (pin_r != pins) ? 3'h0 : (quiet_r == 3'h7) ? quiet_r : quiet_r + 3'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_read_answer: assert property (req_valid && !req.write |=> rvalid)
    else $error("read not answered");
  a_read_cause: assert property (rvalid |-> $past(req_valid && !req.write))
    else $error("rvalid without read");
  a_write_silent: assert property (req_valid && req.write |=> !rvalid)
    else $error("write answered");
  a_ctrl_reserved: assert property (rvalid && $past(req.index) == IDX_CONTROL |-> (rdata & 32'hFFFFC8C8) == 32'h0)
    else $error("reserved control bit set");
  a_status_reserved: assert property (rvalid && $past(req.index) == IDX_STATUS |-> (rdata & 32'hFFFF3838) == 32'h0)
    else $error("reserved status bit set");
  a_unmapped_zero: assert property (rvalid && $past(req.index) > IDX_TWO_FALL |-> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!rvalid |-> $stable(rdata))
    else $error("rdata moved without read");
  a_hit_cause: assert property (probe_one_hit || probe_two_hit |-> quiet_r < 3'h6)
    else $error("hit without trigger edge");
endmodule
bind dpl_latch dpl_chk u_chk (.clk(clk), .reset(reset), .req(req), .req_valid(req_valid),
  .motor_position(motor_position), .probe_input_one(probe_input_one), .probe_input_two(probe_input_two),
  .encoder_index(encoder_index), .encoder_external_input(encoder_external_input), .rdata(rdata),
  .rvalid(rvalid), .probe_one_hit(probe_one_hit), .probe_two_hit(probe_two_hit));

/* dpl_pkg.sv */
/*
  dpl_pkg: constants and carrier types for the dual probe position latch.
  Assumes a 16-bit object index bus from the fieldbus object dictionary logic.
*/
package dpl_pkg;
  localparam logic [15:0] IDX_CONTROL = 16'h60B8;
  localparam logic [15:0] IDX_STATUS = 16'h60B9;
  localparam logic [15:0] IDX_ONE_RISE = 16'h60BA;
  localparam logic [15:0] IDX_ONE_FALL = 16'h60BB;
  localparam logic [15:0] IDX_TWO_RISE = 16'h60BC;
  localparam logic [15:0] IDX_TWO_FALL = 16'h60BD;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_MASK = 16'h3737;
  localparam logic [31:0] POSITION_RESET = 32'h00000000;
  localparam logic [31:0] READ_RESET = 32'h00000000;
  localparam int CH_TWO_BASE = 8;
  localparam int BIT_ENABLE = 0;
  localparam int BIT_CONTINUOUS = 1;
  localparam int BIT_SOURCE_INDEX = 2;
  localparam int BIT_RISE_EN = 4;
  localparam int BIT_FALL_EN = 5;
  localparam int BIT_ST_RISE_DONE = 1;
  localparam int BIT_ST_FALL_DONE = 2;
  localparam int BIT_ST_COUNT = 6;

  typedef struct packed {
    logic fall_en;
    logic rise_en;
    logic source_index;
    logic continuous;
    logic enable;
  } dpl_chan_cfg_s;

  typedef struct packed {
    logic [1:0] count;
    logic fall_done;
    logic rise_done;
    logic enable;
  } dpl_chan_st_s;

  typedef struct packed {
    logic [15:0] index;
    logic write;
    logic [31:0] wdata;
  } dpl_req_s;
endpackage

/* tb_top.sv */
/* tb_top: self-checking bench for dpl_latch.
   assumes dpl_host as the requesting side. */
module tb_top
  import dpl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, rvalid, hit1, hit2, req_valid;
  logic [3:0] pins;
  logic [31:0] pos, rdata, a, b;
  dpl_req_s req;
  logic [31:0] expq[$];
  logic [1:0] hitq[$];
  int err_count = 0;
  int total_checks = 0;
  dpl_host host (.clk(clk), .req(req), .req_valid(req_valid));
  dpl_latch dut (.clk(clk), .reset(reset), .req(req), .req_valid(req_valid), .motor_position(pos),
    .probe_input_one(pins[3]), .probe_input_two(pins[2]), .encoder_index(pins[1]),
    .encoder_external_input(pins[0]), .rdata(rdata), .rvalid(rvalid), .probe_one_hit(hit1), .probe_two_hit(hit2));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %0t read %h expected %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop();
    if (expq.size() > 0 || hitq.size() > 0)
      err_count++;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] e);
    expq.push_back(e);
    host.acc(1'b0, i, 32'h0);
  endtask
  task automatic wr(input logic [31:0] d);
    host.acc(1'b1, IDX_CONTROL, d);
  endtask
  // move one pin; position equals p only in the cycle the capture edge samples
  task automatic tog(input int n, input logic [31:0] p, input logic [1:0] h);
    if (h != 2'h0)
      hitq.push_back(h);
    @(negedge clk);
    pos = ~p;
    pins[n] = ~pins[n];
    repeat (2) @(negedge clk);
    pos = p;
    @(negedge clk);
    pos = ~p;
    repeat (6) @(negedge clk);
  endtask
  always @(negedge clk)
    if (rvalid === 1'b1)
      chk(rdata, expq.size() > 0 ? expq.pop_front() : 32'hX);
  always @(negedge clk)
    if ((hit1 | hit2) === 1'h1)
      chk({30'h0, hit2, hit1}, hitq.size() > 0 ? {30'h0, hitq.pop_front()} : 32'hX);
  initial
  begin
    #200us;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    pins = 4'h0;
    pos = 32'h0;
    reset = 1'b1;
    a = $urandom(32'ha143);
    repeat (3) @(negedge clk);
    reset = 1'b0;
    rd(IDX_CONTROL, 32'h0);
    wr(32'hFFFF);
    rd(IDX_CONTROL, 32'h3737);
    host.acc(1'b1, IDX_ONE_RISE, 32'h1234);
    rd(IDX_ONE_RISE, 32'h0);
    rd(16'h60BE, 32'h0);
    wr(32'h0);
    wr(32'h0033);
    a = $urandom;
    tog(3, a, 2'h1);
    rd(IDX_ONE_RISE, a);
    b = $urandom;
    tog(3, b, 2'h1);
    rd(IDX_ONE_FALL, b);
    rd(IDX_STATUS, 32'h0087);
    for (int k = 0; k < 2; k++)
    begin
      b = $urandom;
      tog(3, b, 2'h1);
    end
    rd(IDX_ONE_FALL, b);
    rd(IDX_STATUS, 32'h0007);
    wr(32'h0);
    rd(IDX_STATUS, 32'h0);
    wr(32'h0025);
    tog(3, $urandom, 2'h0);
    tog(1, $urandom, 2'h0);
    a = $urandom;
    tog(1, a, 2'h1);
    rd(IDX_ONE_FALL, a);
    rd(IDX_STATUS, 32'h0005);
    wr(32'h0);
    wr(32'h1500);
    a = $urandom;
    tog(0, a, 2'h2);
    tog(0, $urandom, 2'h0);
    tog(1, $urandom, 2'h0);
    rd(IDX_TWO_RISE, a);
    rd(IDX_TWO_FALL, 32'h0);
    rd(IDX_STATUS, 32'h0300);
    wr(32'h0);
    wr(32'h1500);
    tog(1, $urandom, 2'h0);
    b = $urandom;
    tog(1, b, 2'h2);
    rd(IDX_TWO_RISE, b);
    wr(32'h0);
    wr(32'h2333);
    a = $urandom;
    tog(3, a, 2'h1);
    tog(2, $urandom, 2'h0);
    b = $urandom;
    tog(2, b, 2'h2);
    rd(IDX_ONE_FALL, a);
    rd(IDX_TWO_FALL, b);
    rd(IDX_STATUS, 32'h4545);
    repeat (3) @(negedge clk);
    report_and_stop();
  end
endmodule
